//--- verilog/bkfr_defines.vh
// Register map, field positions and reset values of the fourth buck regulator control bank.
// Assumes inclusion by bare name from the design files.
`ifndef BKFR_DEFINES_VH
`define BKFR_DEFINES_VH
// ==========================================================
// Register offsets
`define BKFR_ADDR_NORMAL   8'h4a
`define BKFR_ADDR_STANDBY  8'h4b
`define BKFR_ADDR_SLEEP    8'h4c
`define BKFR_ADDR_MODE     8'h4d
`define BKFR_ADDR_CONF     8'h4e
// ==========================================================
// Reset values
`define BKFR_RST_SETPOINT  6'h00
`define BKFR_RST_SWMODE    4'h8
`define BKFR_RST_SLPBEH    1'b0
`define BKFR_RST_CONF      8'h00
// ==========================================================
// Field positions
`define BKFR_SP_MSB        5
`define BKFR_SWMODE_MSB    3
`define BKFR_SLPBEH_BIT    5
`define BKFR_ILIM_BIT      0
`define BKFR_FREQ_LSB      2
`define BKFR_PHASE_LSB     4
`define BKFR_RAMP_LSB      6
// ==========================================================
// Set point code range with a defined voltage, 25 mV per step
`define BKFR_SP_MIN_CODE   6'h09
`define BKFR_SP_MAX_CODE   6'h3f
// Operating states
`define BKFR_ST_NORMAL     2'h0
`define BKFR_ST_STANDBY    2'h1
`define BKFR_ST_SLEEP      2'h2
// Switching mode code driven while tracking: fixed pulse width
`define BKFR_SWMODE_PWM    4'h8
`endif

//--- verilog/bkfr_setpoint_store.v
// Three six-bit set points, one per operating state, with registered read data.
// Assumes a single clock and a write strobe from the register decoder.
`timescale 1ns/1ns
`default_nettype none
`include "bkfr_defines.vh"
module bkfr_setpoint_store #(
	parameter W = 6
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         wr_en,
	input  wire [1:0]   wr_sel,
	input  wire [W-1:0] wr_data,
	input  wire [1:0]   rd_sel,
	output reg  [W-1:0] rd_data_q,
	input  wire [1:0]   app_sel,
	output reg  [W-1:0] app_data_q
);
	reg [W-1:0] mem_q [0:2];
	genvar i;
	// ==========================================================
	// Storage, one entry per state
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ent
			// A genvar cannot be part-selected, so the entry index is sized here
			localparam [1:0] IDX = i;
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					mem_q[i] <= {W{1'b0}};
				end else if (wr_en && wr_sel == IDX) begin
					mem_q[i] <= wr_data;
				end
			end
		end
	endgenerate
	// Registered read ports; index 3 reads as zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q  <= {W{1'b0}};
			app_data_q <= {W{1'b0}};
		end else begin
			rd_data_q  <= (rd_sel == 2'h3) ? {W{1'b0}} : mem_q[rd_sel];
			app_data_q <= (app_sel == 2'h3) ? {W{1'b0}} : mem_q[app_sel];
		end
	end
endmodule // bkfr_setpoint_store
`default_nettype wire

//--- verilog/bkfr_control_regs.v
// Control register bank of the fourth buck regulator, reached by the I2C
// register engine through a simple address, write strobe and read data port.
// Assumes the I2C engine runs on clk and holds the address while reading.
`timescale 1ns/1ns
`default_nettype none
`include "bkfr_defines.vh"
module bkfr_control_regs #(
	parameter TRACK_VARIANT = 1
) (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       startup_done,
	input  wire [1:0] op_state,
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata_q,
	output wire       termination_tracking_mode,
	output reg  [5:0] applied_setpoint_q,
	output reg        setpoint_valid_q,
	output reg  [3:0] applied_switching_mode_q,
	output reg        regulator_enable_q,
	output reg        current_limit_select_q,
	output reg  [1:0] switch_frequency_select_q,
	output reg  [1:0] phase_clock_select_q,
	output reg  [1:0] voltage_ramp_speed_select_q
);
	// ==========================================================
	// Declarations
	reg  [3:0] switching_mode_field_q;
	reg        sleep_behaviour_bit_q;
	reg  [7:0] buck_config_q;
	reg        started_q;
	reg  [1:0] sp_rd_sel;
	reg  [1:0] sp_wr_sel;
	reg        sp_hit;
	reg  [7:0] rdata_d;
	reg  [1:0] op_state_q;
	wire       locked;
	wire       wr_ok;
	wire [5:0] sp_rdata;
	wire [5:0] sp_app;

	// Tracking variants come up in tracking mode; no register can leave it
	assign termination_tracking_mode = (TRACK_VARIANT != 0);

	// ==========================================================
	// Start-up lock: once sequencing ends, tracking parts refuse writes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			started_q <= 1'b0;
		end else if (startup_done) begin
			started_q <= 1'b1;
		end
	end
	assign locked = termination_tracking_mode && started_q;
	assign wr_ok  = reg_wr && !locked;

	// ==========================================================
	// Address decode for set point storage
	always @* begin
		sp_hit    = 1'b0;
		sp_wr_sel = 2'h3;
		case (reg_addr)
			`BKFR_ADDR_NORMAL: begin
				sp_hit    = 1'b1;
				sp_wr_sel = `BKFR_ST_NORMAL;
			end
			`BKFR_ADDR_STANDBY: begin
				sp_hit    = 1'b1;
				sp_wr_sel = `BKFR_ST_STANDBY;
			end
			`BKFR_ADDR_SLEEP: begin
				sp_hit    = 1'b1;
				sp_wr_sel = `BKFR_ST_SLEEP;
			end
			default: begin
				sp_hit    = 1'b0;
				sp_wr_sel = 2'h3;
			end
		endcase
		sp_rd_sel = sp_wr_sel;
	end

	// Set points live in their own store; one port reads, one applies
	bkfr_setpoint_store #(
		.W(6)
	) u_store (
		.clk        (clk),
		.rst_b      (rst_b),
		.wr_en      (wr_ok && sp_hit),
		.wr_sel     (sp_wr_sel),
		.wr_data    (reg_wdata[`BKFR_SP_MSB:0]),
		.rd_sel     (sp_rd_sel),
		.rd_data_q  (sp_rdata),
		.app_sel    (op_state_q),
		.app_data_q (sp_app)
	);

	// ==========================================================
	// Mode and configuration registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			switching_mode_field_q <= `BKFR_RST_SWMODE;
			sleep_behaviour_bit_q  <= `BKFR_RST_SLPBEH;
			buck_config_q          <= `BKFR_RST_CONF;
		end else if (wr_ok) begin
			if (reg_addr == `BKFR_ADDR_MODE) begin
				switching_mode_field_q <= reg_wdata[`BKFR_SWMODE_MSB:0];
				sleep_behaviour_bit_q  <= reg_wdata[`BKFR_SLPBEH_BIT];
			end
			if (reg_addr == `BKFR_ADDR_CONF) begin
				buck_config_q <= reg_wdata;
			end
		end
	end

	// ==========================================================
	// Read mux; set point reads arrive one cycle later from the store,
	// so the bank's read data is aligned by registering everything else
	always @* begin
		case (reg_addr)
			`BKFR_ADDR_MODE:
				rdata_d = {2'b00, sleep_behaviour_bit_q, 1'b0, switching_mode_field_q};
			`BKFR_ADDR_CONF:
				rdata_d = buck_config_q;
			default:
				rdata_d = 8'h00;
		endcase
	end

	reg       rd_sp_q;
	reg [7:0] rd_other_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_sp_q    <= 1'b0;
			rd_other_q <= 8'h00;
		end else begin
			rd_sp_q    <= sp_hit;
			rd_other_q <= rdata_d;
		end
	end

	// Output read data register, two cycles after the address
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= rd_sp_q ? {2'b00, sp_rdata} : rd_other_q;
		end
	end

	// ==========================================================
	// State sample; the state source runs on clk, so no synchroniser
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_state_q <= `BKFR_ST_NORMAL;
		end else begin
			op_state_q <= op_state;
		end
	end

	// ==========================================================
	// Applied controls toward the analog regulator.
	// The set point code is passed through; codes below 9 have no defined
	// voltage, so outside tracking mode they are flagged rather than clamped.
	reg [1:0] app_state_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			app_state_q <= `BKFR_ST_NORMAL;
		end else begin
			app_state_q <= op_state_q;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			applied_setpoint_q          <= `BKFR_RST_SETPOINT;
			setpoint_valid_q            <= 1'b0;
			applied_switching_mode_q    <= `BKFR_RST_SWMODE;
			regulator_enable_q          <= 1'b0;
			current_limit_select_q      <= 1'b0;
			switch_frequency_select_q   <= 2'h0;
			phase_clock_select_q        <= 2'h0;
			voltage_ramp_speed_select_q <= 2'h0;
		end else begin
			// Code drives the DAC: 0.625 V at code 9, +25 mV per code
			applied_setpoint_q <= sp_app;
			setpoint_valid_q   <= termination_tracking_mode
				|| (sp_app >= `BKFR_SP_MIN_CODE);
			if (termination_tracking_mode) begin
				// Reference is half the third buck; analog floor 0.6 V
				applied_switching_mode_q <= `BKFR_SWMODE_PWM;
				regulator_enable_q       <= 1'b1;
			end else if (app_state_q == `BKFR_ST_SLEEP) begin
				applied_switching_mode_q <= sleep_behaviour_bit_q ?
					4'h0 : switching_mode_field_q;
				regulator_enable_q       <= sleep_behaviour_bit_q;
			end else begin
				applied_switching_mode_q <= switching_mode_field_q;
				regulator_enable_q       <= 1'b1;
			end
			current_limit_select_q      <= buck_config_q[`BKFR_ILIM_BIT];
			switch_frequency_select_q   <= buck_config_q[`BKFR_FREQ_LSB+1:`BKFR_FREQ_LSB];
			phase_clock_select_q        <= buck_config_q[`BKFR_PHASE_LSB+1:`BKFR_PHASE_LSB];
			voltage_ramp_speed_select_q <= buck_config_q[`BKFR_RAMP_LSB+1:`BKFR_RAMP_LSB];
		end
	end
endmodule // bkfr_control_regs
`default_nettype wire

//--- sim/bkfr_control_regs_properties.sv
// Port assertions for the fourth buck control bank.
// Assumes binding to bkfr_control_regs; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module bkfr_control_regs_properties #(
	parameter TRACK_VARIANT = 1
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       startup_done,
	input wire logic [1:0] op_state,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       termination_tracking_mode,
	input wire logic [5:0] applied_setpoint_q,
	input wire logic       setpoint_valid_q,
	input wire logic [3:0] applied_switching_mode_q,
	input wire logic       regulator_enable_q,
	input wire logic       current_limit_select_q,
	input wire logic [1:0] switch_frequency_select_q,
	input wire logic [1:0] phase_clock_select_q,
	input wire logic [1:0] voltage_ramp_speed_select_q
);
// ==========================================================
// Relations at the ports
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_b);
// Windows are at least one edge longer than the read path, so a late answer still fails
property p_wr_read;
	(TRACK_VARIANT == 0 && reg_wr && reg_addr == 8'h4a) ##1 (!reg_wr && reg_addr == 8'h4a)[*3] |-> reg_rdata_q == {2'b00, $past(reg_wdata[5:0], 3)};
endproperty
a_wr_read: assert property (p_wr_read) else $error("set point readback wrong");
property p_unmapped;
	(reg_addr > 8'h4e || reg_addr < 8'h4a)[*3] |-> reg_rdata_q == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
property p_unused;
	(reg_addr inside {8'h4a, 8'h4b, 8'h4c, 8'h4d})[*3] |-> reg_rdata_q[7:6] == 2'b00 && (reg_addr != 8'h4d || !reg_rdata_q[4]);
endproperty
a_unused: assert property (p_unused) else $error("unused bit reads one");
property p_track_mode;
	termination_tracking_mode[*3] |-> applied_switching_mode_q == 4'h8 && regulator_enable_q;
endproperty
a_track_mode: assert property (p_track_mode) else $error("tracking not fixed pulse width");
property p_sleep_pfm;
	(op_state == 2'h2 && !termination_tracking_mode)[*3] ##1 (op_state == 2'h2 && regulator_enable_q) |-> applied_switching_mode_q == 4'h0;
endproperty
a_sleep_pfm: assert property (p_sleep_pfm) else $error("sleep on but not pulse frequency");
property p_applied_sp;
	(!termination_tracking_mode && !reg_wr && reg_addr == 8'h4a + {6'h00, op_state} && $stable(op_state))[*4] |-> applied_setpoint_q == reg_rdata_q[5:0];
endproperty
a_applied_sp: assert property (p_applied_sp) else $error("applied set point not the state's");
property p_conf;
	(reg_addr == 8'h4e && !reg_wr)[*4] |-> reg_rdata_q == {voltage_ramp_speed_select_q, phase_clock_select_q, switch_frequency_select_q, reg_rdata_q[1], current_limit_select_q};
endproperty
a_conf: assert property (p_conf) else $error("config outputs differ from register");
property p_mode_norm;
	(!termination_tracking_mode && op_state == 2'h0 && reg_addr == 8'h4d && !reg_wr)[*4] |-> applied_switching_mode_q == reg_rdata_q[3:0] && regulator_enable_q;
endproperty
a_mode_norm: assert property (p_mode_norm) else $error("normal mode not the field");
endmodule // bkfr_control_regs_properties
`default_nettype wire

//--- sim/bkfr_host_model.sv
// Host side of the register port, as the I2C engine presents it.
// Assumes read data settles two edges after the address.
`timescale 1ns/1ns
`default_nettype none
module bkfr_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output var  logic [7:0] addr,
	output var  logic       wr,
	output var  logic [7:0] wdata
);
// ==========================================================
// Transfers
initial begin
	addr = 8'h00;
	wr = 1'b0;
	wdata = 8'h00;
end
// One byte; data is inverted once the strobe drops so stale data never matches
task automatic put(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk);
	addr <= a;
	wr <= 1'b1;
	wdata <= d;
	@(posedge clk);
	wr <= 1'b0;
	wdata <= ~d;
endtask
// Address held three edges, one more than the bank needs
task automatic get(input logic [7:0] a, output logic [7:0] d);
	@(posedge clk);
	addr <= a;
	repeat (3) @(posedge clk);
	d = rdata;
endtask
endmodule // bkfr_host_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench: register table pass, then state, config and lock tests.
// Assumes the host model; a tracking twin shares the port to show the lock.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("unexpected %0t: %h not %h", $time, g, e); end end
module testbench;
typedef struct packed {logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} bkfr_row_t;
logic            clk = 1'b0;
logic            rst_b = 1'b0;
logic            startup_done = 1'b0;
logic      [1:0] op_state = 2'h0;
wire logic [7:0] addr, wdata, rd, rd2;
wire logic [5:0] sp;
wire logic [3:0] md, md2;
wire logic [1:0] fq, ph, rs;
wire logic       wr, tt, tt2, vld, en, il;
int              n_errors = 0;
int              checks_done = 0;
bkfr_row_t       rows [7] = '{'{8'h4a, 8'h00, 8'h15, 8'h15}, '{8'h4b, 8'h00, 8'hff, 8'h3f}, '{8'h4c, 8'h00, 8'hc9, 8'h09},
	'{8'h4d, 8'h08, 8'hff, 8'h2f}, '{8'h4e, 8'h00, 8'ha5, 8'ha5}, '{8'h50, 8'h00, 8'hff, 8'h00}, '{8'h49, 8'h00, 8'hff, 8'h00}};
logic      [5:0] exp_sp [3] = '{6'h15, 6'h3f, 6'h09};
logic      [3:0] exp_md [3] = '{4'hf, 4'hf, 4'h0};
bkfr_host_model host (.clk, .rdata(rd), .addr, .wr, .wdata);
bkfr_control_regs #(.TRACK_VARIANT(0)) dut (.clk, .rst_b, .startup_done, .op_state, .reg_addr(addr), .reg_wr(wr),
	.reg_wdata(wdata), .reg_rdata_q(rd), .termination_tracking_mode(tt), .applied_setpoint_q(sp), .setpoint_valid_q(vld),
	.applied_switching_mode_q(md), .regulator_enable_q(en), .current_limit_select_q(il),
	.switch_frequency_select_q(fq), .phase_clock_select_q(ph), .voltage_ramp_speed_select_q(rs));
bkfr_control_regs #(.TRACK_VARIANT(1)) dut2 (.clk, .rst_b, .startup_done, .op_state, .reg_addr(addr), .reg_wr(wr),
	.reg_wdata(wdata), .reg_rdata_q(rd2), .termination_tracking_mode(tt2), .applied_setpoint_q(), .setpoint_valid_q(),
	.applied_switching_mode_q(md2), .regulator_enable_q(), .current_limit_select_q(), .switch_frequency_select_q(),
	.phase_clock_select_q(), .voltage_ramp_speed_select_q());
// ==========================================================
// Clock, verdict and hang guard
always #4 clk = ~clk;
task automatic give_verdict;
	if (n_errors == 0 && checks_done > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
initial begin
	#200000;
	n_errors++;
	give_verdict();
end
// ==========================================================
// Main sequence
initial begin
	logic [7:0] v;
	repeat (8) @(posedge clk);
	rst_b <= 1'b1;
	repeat (4) @(posedge clk);
	`CHK(vld, 1'b0)
	`CHK(md, 4'h8)
	`CHK({tt2, tt}, 2'b10)
	// Reset value, write, readback; the twin accepts writes until start-up ends
	foreach (rows[i]) begin
		host.get(rows[i].a, v);
		`CHK(v, rows[i].r)
		host.put(rows[i].a, rows[i].w);
		host.get(rows[i].a, v);
		`CHK(v, rows[i].e)
		`CHK(rd2, rows[i].e)
	end
	// Walk normal, standby and sleep with the sleep bit set
	for (int s = 0; s < 3; s++) begin
		op_state <= s[1:0];
		host.get(8'h4a + s[7:0], v);
		repeat (2) @(posedge clk);
		`CHK(sp, exp_sp[s])
		`CHK({md, en, vld, md2}, {exp_md[s], 2'b11, 4'h8})
	end
	host.put(8'h4d, 8'h08);
	repeat (5) @(posedge clk);
	`CHK(en, 1'b0)
	`CHK({rs, ph, fq, il}, 7'h53)
	// After start-up only the writable variant takes a new voltage
	op_state <= 2'h0;
	startup_done <= 1'b1;
	host.put(8'h4a, 8'h20);
	host.get(8'h4a, v);
	`CHK(v, 8'h20)
	`CHK(rd2, 8'h15)
	give_verdict();
end
endmodule // testbench
bind bkfr_control_regs bkfr_control_regs_properties #(.TRACK_VARIANT(TRACK_VARIANT)) chk (.clk, .rst_b, .startup_done,
	.op_state, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_q, .termination_tracking_mode, .applied_setpoint_q,
	.setpoint_valid_q, .applied_switching_mode_q, .regulator_enable_q, .current_limit_select_q,
	.switch_frequency_select_q, .phase_clock_select_q, .voltage_ramp_speed_select_q);
`default_nettype wire
